// *** rtl/arith_exec_pkg.sv ***
// shared types and constants for the arithmetic execution timing unit
package arith_exec_pkg;

  localparam int DATA_W = 32;
  localparam int WAIT_W = 4;
  localparam int CNT_W = 8;
  localparam logic [31:0] ONE_EXT_UPPER = 32'hffff0000;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;
  localparam logic [2:0] STEP_FOUR = 3'h4;
  localparam logic [CNT_W-1:0] PORT_EXTRA_ARITH = 8'h01;
  localparam logic [CNT_W-1:0] SFR_EXTRA_ARITH = 8'h02;
  localparam logic [CNT_W-1:0] PORT_EXTRA_INCDEC = 8'h02;
  localparam logic [CNT_W-1:0] SFR_EXTRA_INCDEC = 8'h03;
  localparam logic [CNT_W-1:0] EXT_BASE_EXTRA = 8'h02;
  // encoded byte counts and base state counts of the instruction forms
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;
  localparam logic [2:0] LEN_FIVE = 3'h5;
  localparam logic [CNT_W-1:0] ST_ONE = 8'h01;
  localparam logic [CNT_W-1:0] ST_TWO = 8'h02;
  localparam logic [CNT_W-1:0] ST_THREE = 8'h03;
  localparam logic [CNT_W-1:0] ST_FOUR = 8'h04;
  localparam logic [CNT_W-1:0] ST_FIVE = 8'h05;
  localparam logic [CNT_W-1:0] ST_SIX = 8'h06;

  typedef enum logic [3:0] {
    op_add = 4'h0,
    op_subtract = 4'h1,
    add_carry_op = 4'h2,
    subtract_borrow_op = 4'h3,
    op_increment = 4'h4,
    decrement_op = 4'h5,
    compare_op = 4'h6
  } op_type;

  // operand combination
  typedef enum logic [3:0] {
    f_acc_reg = 4'h0,
    f_acc_direct = 4'h1,
    f_acc_indirect = 4'h2,
    f_acc_imm = 4'h3,
    f_byte_byte = 4'h4,
    f_word_word = 4'h5,
    f_long_long = 4'h6,
    f_byte_imm8 = 4'h7,
    f_word_imm16 = 4'h8,
    f_long_imm16 = 4'h9,
    f_byte_direct_addr_8b = 4'ha,
    f_word_direct_addr_8b = 4'hb,
    f_byte_direct_addr_16b = 4'hc,
    f_word_direct_addr_16b = 4'hd,
    f_byte_ind_word = 4'he,
    f_byte_ind_long = 4'hf
  } form_type;

  // what the memory operand hits
  typedef enum logic [1:0] {
    tgt_internal = 2'h0,
    tgt_port = 2'h1,
    tgt_periph = 2'h2,
    tgt_external = 2'h3
  } target_type;

  typedef struct packed {
    op_type op;
    form_type form;
    target_type target;
    logic source_mode;
    logic one_ext;
    logic [2:0] step;
    logic [DATA_W-1:0] dest;
    logic [DATA_W-1:0] src;
    logic carry_flag;
  } request_type;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic write_back;
    logic carry_flag;
    logic zero;
    logic [2:0] length;
    logic [CNT_W-1:0] states;
  } result_type;

endpackage : arith_exec_pkg

// *** rtl/arith_instr_exec_timing.sv ***
// arithmetic instruction execution with per-form length and state timing
// Notes on behaviour
// - increment adds one, or adds source to destination in two-operand form.
// - compare forms destination minus source and never writes it back.
// - carry forms use accumulator and carry; register source 1/1 binary, 2/2 source.
// - accumulator plus indirect byte: 1 byte 2 states binary, 2 bytes 3 source.
// - accumulator plus direct byte: 2 bytes, 1 base state, plus target extras.
// - byte register pair: 3 bytes 2 states binary, 2 bytes 1 source.
// - long register pair: 3 bytes 5 states binary, 2 bytes 4 source.
// - word with 16-bit immediate: 5 bytes 4 states binary, 4 bytes 3 source.
// - long with zero-extended immediate: 5 bytes 6 states, 4 bytes 5 source.
// - byte with 8-bit immediate: 4 bytes 3 states binary, 3 bytes 2 source.
// - word with direct on-chip word: 4 bytes 4 states, 3 bytes 3 source.
// - word with 64K direct word: 5 bytes 4 states, 4 bytes 3 source.
// - byte through long pointer: 4 bytes 4 states, 3 bytes 3 source.
// - add/subtract port access adds one state, peripheral register adds two.
// - increment/decrement direct: port adds two states, peripheral register three.
// - external byte access adds wait states plus two.
// - external word direct access adds twice the sum of wait states and two.
// - byte register short step only 1, 2 or 4; 3/2 binary, 2/1 source.
// - long step increment 4/3 states, decrement 5/4; 3 and 2 bytes.
// - increment/decrement indirect byte: 1 byte 3 states, 2 bytes 4 source.
// - compare long with one-extended immediate: 5 bytes 6 states, 4 bytes 5.
// - compare long pair: 3 bytes 5 states binary, 2 bytes 4 source.
module arith_instr_exec_timing #(
  parameter int WAIT_STATES = 0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // request from decode
  input wire logic req_valid,
  output logic req_ready,
  input arith_exec_pkg::request_type req,
  // result to register file and memory
  output logic done,
  output logic illegal_step,
  output arith_exec_pkg::result_type result
);
  import arith_exec_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_busy = 2'b10
  } state_type;

  localparam logic [CNT_W-1:0] WAIT_N = CNT_W'(WAIT_STATES);

  state_type state_q;
  logic [CNT_W-1:0] count_q;
  result_type result_q;
  logic done_q;
  logic illegal_q;
  logic start;

  // packs the byte count and state count for a form
  function automatic logic [CNT_W+2:0] timing(input logic [2:0] len,
                                               input logic [CNT_W-1:0] st);
    timing = {len, st};
  endfunction : timing

  function automatic logic step_ok(input logic [2:0] s);
    step_ok = (s == STEP_ONE) || (s == STEP_TWO) || (s == STEP_FOUR);
  endfunction : step_ok

  // base length and states per form, binary then source mode
  logic [CNT_W+2:0] base_t;
  logic [CNT_W-1:0] extra;
  logic is_incdec;
  always_comb begin
    is_incdec = (req.op == op_increment) || (req.op == decrement_op);
    base_t = '0;
    case (req.form)
      f_acc_reg: begin
        base_t = req.source_mode ? timing(LEN_TWO, ST_TWO) : timing(LEN_ONE, ST_ONE);
      end
      f_acc_direct: begin
        if (is_incdec) begin
          base_t = timing(LEN_TWO, ST_TWO);
        end else begin
          base_t = timing(LEN_TWO, ST_ONE);
        end
      end
      f_acc_indirect: begin
        if (is_incdec) begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_FOUR) : timing(LEN_ONE, ST_THREE);
        end else begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_THREE) : timing(LEN_ONE, ST_TWO);
        end
      end
      f_acc_imm: begin
        base_t = timing(LEN_TWO, ST_ONE);
      end
      f_byte_byte: begin
        base_t = req.source_mode ? timing(LEN_TWO, ST_ONE) : timing(LEN_THREE, ST_TWO);
      end
      f_word_word: begin
        base_t = req.source_mode ? timing(LEN_TWO, ST_TWO) : timing(LEN_THREE, ST_THREE);
      end
      f_long_long: begin
        if (is_incdec && req.op == op_increment) begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_THREE) : timing(LEN_THREE, ST_FOUR);
        end else if (is_incdec) begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_FOUR) : timing(LEN_THREE, ST_FIVE);
        end else begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_FOUR) : timing(LEN_THREE, ST_FIVE);
        end
      end
      f_byte_imm8: begin
        if (is_incdec) begin
          base_t = req.source_mode ? timing(LEN_TWO, ST_ONE) : timing(LEN_THREE, ST_TWO);
        end else begin
          base_t = req.source_mode ? timing(LEN_THREE, ST_TWO) : timing(LEN_FOUR, ST_THREE);
        end
      end
      f_word_imm16: begin
        base_t = req.source_mode ? timing(LEN_FOUR, ST_THREE) : timing(LEN_FIVE, ST_FOUR);
      end
      f_long_imm16: begin
        base_t = req.source_mode ? timing(LEN_FOUR, ST_FIVE) : timing(LEN_FIVE, ST_SIX);
      end
      f_byte_direct_addr_8b: begin
        base_t = req.source_mode ? timing(LEN_THREE, ST_TWO) : timing(LEN_FOUR, ST_THREE);
      end
      f_word_direct_addr_8b: begin
        base_t = req.source_mode ? timing(LEN_THREE, ST_THREE) : timing(LEN_FOUR, ST_FOUR);
      end
      f_byte_direct_addr_16b: begin
        base_t = req.source_mode ? timing(LEN_FOUR, ST_TWO) : timing(LEN_FIVE, ST_THREE);
      end
      f_word_direct_addr_16b: begin
        base_t = req.source_mode ? timing(LEN_FOUR, ST_THREE) : timing(LEN_FIVE, ST_FOUR);
      end
      f_byte_ind_word: begin
        base_t = req.source_mode ? timing(LEN_THREE, ST_TWO) : timing(LEN_FOUR, ST_THREE);
      end
      f_byte_ind_long: begin
        base_t = req.source_mode ? timing(LEN_THREE, ST_THREE) : timing(LEN_FOUR, ST_FOUR);
      end
      default: begin
        base_t = '0;
      end
    endcase
  end

  // penalty states from the kind of target touched
  always_comb begin
    extra = '0;
    case (req.target)
      tgt_port: begin
        extra = is_incdec ? PORT_EXTRA_INCDEC : PORT_EXTRA_ARITH;
      end
      tgt_periph: begin
        extra = is_incdec ? SFR_EXTRA_INCDEC : SFR_EXTRA_ARITH;
      end
      tgt_external: begin
        if (req.form == f_word_direct_addr_16b) begin
          extra = CNT_W'((WAIT_N + EXT_BASE_EXTRA) << 1);
        end else begin
          extra = WAIT_N + EXT_BASE_EXTRA;
        end
      end
      default: begin
        extra = '0;
      end
    endcase
  end

  // arithmetic
  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] src_eff;
  logic bad_step;
  logic wb;
  always_comb begin
    src_eff = req.src;
    bad_step = 1'b0;
    if (req.form == f_long_imm16) begin
      src_eff = req.one_ext ? (ONE_EXT_UPPER | {16'h0000, req.src[15:0]})
                            : {16'h0000, req.src[15:0]};
    end
    wb = 1'b1;
    case (req.op)
      op_add: sum = {1'b0, req.dest} + {1'b0, src_eff};
      op_subtract: sum = {1'b0, req.dest} - {1'b0, src_eff};
      add_carry_op: sum = {1'b0, req.dest} + {1'b0, src_eff} + {32'h0, req.carry_flag};
      subtract_borrow_op: sum = {1'b0, req.dest} - {1'b0, src_eff} - {32'h0, req.carry_flag};
      op_increment: begin
        if (req.form == f_byte_imm8 || req.form == f_long_long) begin
          bad_step = !step_ok(req.step);
          sum = {1'b0, req.dest} + {30'h0, req.step};
        end else if (req.form == f_acc_reg || req.form == f_acc_direct
                     || req.form == f_acc_indirect) begin
          sum = {1'b0, req.dest} + 33'h1;
        end else begin
          sum = {1'b0, req.dest} + {1'b0, src_eff};
        end
      end
      decrement_op: begin
        if (req.form == f_byte_imm8 || req.form == f_long_long) begin
          bad_step = !step_ok(req.step);
          sum = {1'b0, req.dest} - {30'h0, req.step};
        end else begin
          sum = {1'b0, req.dest} - 33'h1;
        end
      end
      compare_op: begin
        sum = {1'b0, req.dest} - {1'b0, src_eff};
        wb = 1'b0;
      end
      default: begin
        sum = '0;
        wb = 1'b0;
      end
    endcase
  end

  assign req_ready = (state_q == st_idle);
  assign start = req_valid && req_ready;
  assign done = done_q;
  assign illegal_step = illegal_q;
  assign result = result_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= st_idle;
      count_q <= '0;
    end else begin
      case (state_q)
        st_idle: begin
          if (start) begin
            state_q <= st_busy;
            count_q <= base_t[CNT_W-1:0] + extra - CNT_W'(1);
          end
        end
        st_busy: begin
          if (count_q == '0) begin
            state_q <= st_idle;
          end else begin
            count_q <= count_q - CNT_W'(1);
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      result_q <= '0;
      illegal_q <= 1'b0;
    end else if (start) begin
      result_q.value <= sum[DATA_W-1:0];
      result_q.write_back <= wb && !bad_step;
      result_q.carry_flag <= sum[DATA_W];
      result_q.zero <= (sum[DATA_W-1:0] == '0);
      result_q.length <= base_t[CNT_W+2:CNT_W];
      result_q.states <= base_t[CNT_W-1:0] + extra;
      illegal_q <= bad_step;
    end
  end

  // done pulses one cycle after the last counted state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == st_busy) && (count_q == '0);
    end
  end

  // done stays low while states remain, then pulses as the unit frees up
  chk_done_after_count: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == st_busy && count_q != '0 |=> !done && state_q == st_busy)
    else $error("done raised too early");
  chk_done_on_last: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == st_busy && count_q == '0 |=> done && state_q == st_idle)
    else $error("done missing after last state");
  chk_ready_with_done: assert property (@(posedge sys_clk) disable iff (reset)
    done |-> req_ready)
    else $error("not ready while done");
  chk_compare_no_write: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.op == compare_op |=> !result_q.write_back)
    else $error("compare wrote back");
  // a request offered while busy must leave the held result alone
  chk_busy_blocks_req: assert property (@(posedge sys_clk) disable iff (reset)
    state_q == st_busy && req_valid |=> $stable(result_q))
    else $error("accepted while busy");

  sequence long_imm_taken;
    start && req.form == f_long_imm16 && !req.source_mode && req.target == tgt_internal;
  endsequence
  // done is seen one edge after the last counted state
  sequence long_imm_timing;
    result_q.states == ST_SIX ##6 done;
  endsequence
  chk_long_imm_states: assert property (@(posedge sys_clk) disable iff (reset)
    long_imm_taken |=> long_imm_timing)
    else $error("long immediate timing wrong");
  chk_port_penalty: assert property (@(posedge sys_clk) disable iff (reset)
    start && !is_incdec && req.target == tgt_port && req.form == f_acc_direct
    |=> result_q.states == 8'h02)
    else $error("port penalty wrong");
  chk_bad_step: assert property (@(posedge sys_clk) disable iff (reset)
    start && is_incdec && req.form == f_byte_imm8 && !step_ok(req.step)
    |=> illegal_step && !result_q.write_back)
    else $error("bad step accepted");
  chk_ext_word: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.form == f_word_direct_addr_16b && req.target == tgt_external && !req.source_mode
    |=> result_q.states == CNT_W'(ST_FOUR + ((WAIT_N + EXT_BASE_EXTRA) << 1)))
    else $error("external word penalty wrong");
  chk_inc_one: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.op == op_increment && req.form == f_acc_reg
    |=> result_q.value == $past(req.dest) + 32'h1)
    else $error("increment value wrong");
  chk_acc_ind_states: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.form == f_acc_indirect && !is_incdec && !req.source_mode
    && req.target == tgt_internal |=> result_q.length == LEN_ONE && result_q.states == ST_TWO)
    else $error("indirect accumulator timing wrong");
  chk_incdec_port: assert property (@(posedge sys_clk) disable iff (reset)
    start && is_incdec && req.form == f_acc_direct && req.target == tgt_port
    |=> result_q.states == ST_TWO + PORT_EXTRA_INCDEC)
    else $error("increment port penalty wrong");
  chk_ext_byte: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.form == f_byte_ind_long && req.target == tgt_external && !req.source_mode
    |=> result_q.states == ST_FOUR + WAIT_N + EXT_BASE_EXTRA)
    else $error("external byte penalty wrong");
  chk_carry_sum: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.op == add_carry_op && req.form == f_acc_reg
    |=> result_q.value == $past(req.dest) + $past(req.src) + {31'h0, $past(req.carry_flag)})
    else $error("carry add value wrong");
  chk_long_step: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.op == decrement_op && req.form == f_long_long && !req.source_mode
    && req.target == tgt_internal |=> result_q.length == LEN_THREE && result_q.states == ST_FIVE)
    else $error("long decrement timing wrong");
  chk_one_ext_src: assert property (@(posedge sys_clk) disable iff (reset)
    start && req.op == compare_op && req.form == f_long_imm16 && req.one_ext
    |=> result_q.value == $past(req.dest) - (ONE_EXT_UPPER | {16'h0000, $past(req.src[15:0])}))
    else $error("one-extended compare value wrong");
endmodule : arith_instr_exec_timing

// *** tb/arith_instr_exec_timing_tb_top.sv ***
// self-checking bench for the arithmetic execution timing unit
module arith_instr_exec_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import arith_exec_pkg::*;
  // wait states are kept small so external penalties stay short
  localparam int NW = 3;
  logic sys_clk;
  logic reset;
  logic req_valid;
  logic req_ready;
  request_type req;
  logic done;
  logic illegal_step;
  result_type result;
  int n_mismatch;
  int checks;

  arith_instr_exec_timing #(.WAIT_STATES(NW)) DUT (
    .sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .done(done), .illegal_step(illegal_step), .result(result));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // counts edges after the taking edge until done; a lost pulse ends the run
  task automatic wait_done(output int k);
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k >= 40) begin
      n_mismatch++;
      $display("BAD done_wait expected pulse seen none");
      end_of_test();
    end
  endtask : wait_done

  // dest 10h, src 05h and carry set on every request
  task automatic go(input op_type op, input form_type fm, input target_type tg, input logic sm,
      input logic [2:0] stp, input int len, input int st, input logic [31:0] val,
      input logic wb);
    int k;
    req = '{op, fm, tg, sm, op == compare_op, stp, 32'h10, 32'h5, 1'b1};
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    chk("length", len, {29'h0, result.length});
    chk("states", st, {24'h0, result.states});
    chk("write_back", {31'h0, wb}, {31'h0, result.write_back});
    chk("illegal_step", 32'h0, {31'h0, illegal_step});
    chk("value", val, result.value);
    // only the one-extended compare borrows with these operands
    chk("carry_out", {31'h0, op == compare_op && fm == f_long_imm16},
        {31'h0, result.carry_flag});
    chk("zero", 32'h0, {31'h0, result.zero});
    chk("ready_busy", 32'h0, {31'h0, req_ready});
    wait_done(k);
    chk("done_delay", st, k);
    chk("ready_back", 32'h1, {31'h0, req_ready});
  endtask : go

  task automatic test_acc();
    go(add_carry_op, f_acc_reg, tgt_internal, 0, 0, 1, 1, 32'h16, 1);
    go(subtract_borrow_op, f_acc_reg, tgt_internal, 1, 0, 2, 2, 32'h0a, 1);
    go(op_add, f_acc_indirect, tgt_internal, 0, 0, 1, 2, 32'h15, 1);
    go(op_add, f_acc_indirect, tgt_internal, 1, 0, 2, 3, 32'h15, 1);
    go(op_add, f_acc_direct, tgt_internal, 1, 0, 2, 1, 32'h15, 1);
    go(op_add, f_acc_direct, tgt_port, 0, 0, 2, 2, 32'h15, 1);
    go(op_subtract, f_acc_direct, tgt_periph, 1, 0, 2, 3, 32'h0b, 1);
    $display("test_acc finished");
  endtask : test_acc

  task automatic test_regs();
    go(op_subtract, f_byte_byte, tgt_internal, 0, 0, 3, 2, 32'h0b, 1);
    go(op_subtract, f_byte_byte, tgt_internal, 1, 0, 2, 1, 32'h0b, 1);
    go(op_add, f_long_long, tgt_internal, 0, 0, 3, 5, 32'h15, 1);
    go(op_add, f_long_long, tgt_internal, 1, 0, 2, 4, 32'h15, 1);
    go(op_subtract, f_word_imm16, tgt_internal, 0, 0, 5, 4, 32'h0b, 1);
    go(op_subtract, f_word_imm16, tgt_internal, 1, 0, 4, 3, 32'h0b, 1);
    go(op_add, f_long_imm16, tgt_internal, 0, 0, 5, 6, 32'h15, 1);
    go(op_add, f_long_imm16, tgt_internal, 1, 0, 4, 5, 32'h15, 1);
    go(op_add, f_byte_imm8, tgt_internal, 0, 0, 4, 3, 32'h15, 1);
    go(op_add, f_byte_imm8, tgt_internal, 1, 0, 3, 2, 32'h15, 1);
    go(op_subtract, f_word_direct_addr_8b, tgt_internal, 0, 0, 4, 4, 32'h0b, 1);
    go(op_subtract, f_word_direct_addr_8b, tgt_internal, 1, 0, 3, 3, 32'h0b, 1);
    go(op_add, f_acc_imm, tgt_internal, 0, 0, 2, 1, 32'h15, 1);
    go(op_subtract, f_word_word, tgt_internal, 0, 0, 3, 3, 32'h0b, 1);
    go(op_add, f_byte_direct_addr_8b, tgt_port, 0, 0, 4, 4, 32'h15, 1);
    go(op_add, f_byte_ind_word, tgt_internal, 1, 0, 3, 2, 32'h15, 1);
    $display("test_regs finished");
  endtask : test_regs

  task automatic test_ext();
    go(op_add, f_word_direct_addr_16b, tgt_internal, 0, 0, 5, 4, 32'h15, 1);
    go(op_add, f_word_direct_addr_16b, tgt_external, 1, 0, 4, 3 + 2 * (NW + 2), 32'h15, 1);
    go(op_add, f_word_direct_addr_16b, tgt_external, 0, 0, 5, 4 + 2 * (NW + 2), 32'h15, 1);
    go(op_subtract, f_byte_direct_addr_16b, tgt_external, 1, 0, 4, 2 + NW + 2, 32'h0b, 1);
    go(op_subtract, f_byte_ind_long, tgt_internal, 1, 0, 3, 3, 32'h0b, 1);
    go(op_subtract, f_byte_ind_long, tgt_external, 0, 0, 4, 4 + NW + 2, 32'h0b, 1);
    $display("test_ext finished");
  endtask : test_ext

  task automatic test_incdec();
    int k;
    go(op_increment, f_acc_reg, tgt_internal, 0, 0, 1, 1, 32'h11, 1);
    go(op_increment, f_word_word, tgt_internal, 1, 0, 2, 2, 32'h15, 1);
    go(op_increment, f_acc_direct, tgt_port, 0, 0, 2, 4, 32'h11, 1);
    go(decrement_op, f_acc_direct, tgt_periph, 1, 0, 2, 5, 32'h0f, 1);
    go(op_increment, f_acc_indirect, tgt_internal, 0, 0, 1, 3, 32'h11, 1);
    go(decrement_op, f_acc_indirect, tgt_internal, 1, 0, 2, 4, 32'h0f, 1);
    go(op_increment, f_byte_imm8, tgt_internal, 0, 4, 3, 2, 32'h14, 1);
    go(decrement_op, f_byte_imm8, tgt_internal, 1, 1, 2, 1, 32'h0f, 1);
    go(op_increment, f_long_long, tgt_internal, 0, 2, 3, 4, 32'h12, 1);
    go(op_increment, f_long_long, tgt_internal, 1, 4, 2, 3, 32'h14, 1);
    go(decrement_op, f_long_long, tgt_internal, 0, 2, 3, 5, 32'h0e, 1);
    go(decrement_op, f_long_long, tgt_internal, 1, 2, 2, 4, 32'h0e, 1);
    // a step of three is not encodable and must be flagged
    req = '{op_increment, f_byte_imm8, tgt_internal, 1'b0, 1'b0, 3'h3, 32'h10, 32'h5, 1'b0};
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    chk("illegal_step", 32'h1, {31'h0, illegal_step});
    chk("bad_step_write", 32'h0, {31'h0, result.write_back});
    wait_done(k);
    chk("bad_step_done", 32'h2, k);
    $display("test_incdec finished");
  endtask : test_incdec

  task automatic test_compare();
    go(compare_op, f_long_imm16, tgt_internal, 0, 0, 5, 6, 32'h0001000b, 0);
    go(compare_op, f_long_imm16, tgt_internal, 1, 0, 4, 5, 32'h0001000b, 0);
    go(compare_op, f_long_long, tgt_internal, 0, 0, 3, 5, 32'h0b, 0);
    go(compare_op, f_long_long, tgt_internal, 1, 0, 2, 4, 32'h0b, 0);
    $display("test_compare finished");
  endtask : test_compare

  // a second request offered while busy is held off until the first is done
  task automatic test_refused();
    int k;
    req = '{op_add, f_long_long, tgt_internal, 1'b0, 1'b0, 3'h0, 32'h10, 32'h5, 1'b0};
    req_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    req = '{compare_op, f_byte_byte, tgt_internal, 1'b1, 1'b0, 3'h0, 32'h5, 32'h5, 1'b0};
    repeat (3) begin
      chk("held_value", 32'h15, result.value);
      @(posedge sys_clk);
      #1;
    end
    wait_done(k);
    chk("first_done", 32'h2, k);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    chk("cmp_zero", 32'h1, {31'h0, result.zero});
    chk("cmp_write", 32'h0, {31'h0, result.write_back});
    chk("cmp_states", 32'h1, {24'h0, result.states});
    wait_done(k);
    chk("second_done", 32'h1, k);
    $display("test_refused finished");
  endtask : test_refused

  initial begin
    n_mismatch = 0;
    checks = 0;
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("ready_in_reset", 32'h1, {31'h0, req_ready});
    chk("done_in_reset", 32'h0, {31'h0, done});
    chk("result_in_reset", 32'h0, result.value);
    reset = 1'b0;
    $display("test_reset finished");
    test_acc();
    test_regs();
    test_ext();
    test_incdec();
    test_compare();
    test_refused();
    end_of_test();
  end
endmodule : arith_instr_exec_timing_tb_top
